/* File: verilog/fpc_pkg.sv */
package fpc_pkg;

  // ==========================================================
  // widths and geometry
  localparam int ADDR_W   = 32;
  localparam int WORD_W   = 32;
  localparam int LINE_W   = 128;
  localparam int LINE_A_W = 28;
  localparam int TAG_W    = 27;
  localparam int N_PORTS  = 2;
  localparam int N_ENTRY  = 4;
  localparam int IDX_W    = 2;
  localparam int MST_W    = 2;
  localparam int N_MST    = 4;
  localparam int WS_W     = 4;
  localparam int CFG_W    = 8;

  // ==========================================================
  // address fields
  localparam int SET_BIT   = 4;
  localparam int TAG_LSB   = 5;
  localparam int WSEL_LSB  = 2;
  localparam int LINE_LSB  = 4;

  // ==========================================================
  // prefetch configuration fields, one byte per port
  localparam int PF_MST_EN_LSB = 0;
  localparam int PF_INSTR_BIT  = 4;
  localparam int PF_DATA_BIT   = 5;
  localparam int PF_ALGO_LSB   = 6;
  localparam logic [1:0] PF_ALGO_OFF  = 2'h0;
  localparam logic [1:0] PF_ALGO_MISS = 2'h1;
  localparam logic [1:0] PF_ALGO_HIT  = 2'h2;
  localparam logic [1:0] PF_ALGO_ALL  = 2'h3;
  localparam logic [CFG_W-1:0] PF_CFG_RST = 8'h00;

  // ==========================================================
  // arbitration configuration fields
  localparam int ARB_RR_BIT    = 0;
  localparam int ARB_SPLIT_BIT = 1;
  localparam int ARB_BOOT_BIT  = 2;
  localparam int ARB_WS_LSB    = 4;
  localparam logic [CFG_W-1:0] ARB_CFG_RST = 8'hf0;

  // ==========================================================
  // ahb encodings
  localparam int HTRANS_ACT_BIT = 1;
  localparam int HPROT_DATA_BIT = 0;

  // ==========================================================
  // state machines
  typedef enum logic [2:0] {
    PS_IDLE = 3'h0,
    PS_LOOK = 3'h1,
    PS_HIT  = 3'h2,
    PS_MISS = 3'h3,
    PS_ERR  = 3'h4
  } fpc_port_state_t;

  typedef enum logic [1:0] {
    AS_IDLE = 2'h0,
    AS_BUSY = 2'h1,
    AS_DONE = 2'h2
  } fpc_arb_state_t;

endpackage : fpc_pkg

/* File: verilog/fpc_line_mem.sv */
`timescale 1ns/1ns
// ==========================================================
// line storage, registered read port
module fpc_line_mem #(
  parameter int DEPTH = 4,
  parameter int WIDTH = 128,
  parameter int IW    = 2
) (
  input  wire logic             sys_clk,
  input  wire logic             nrst,
  input  wire logic             wr_en,
  input  wire logic [IW-1:0]    wr_idx,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic             rd_en,
  input  wire logic [IW-1:0]    rd_idx,
  output logic      [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [WIDTH-1:0] rd_reg;
  logic [WIDTH-1:0] rd_next;

  // read data only moves on a read strobe
  always_comb begin
    rd_next = rd_reg;
    if (rd_en) begin
      rd_next = mem_reg[rd_idx];
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rd_reg <= '0;
    end else begin
      rd_reg <= rd_next;
    end
  end

  // storage has no reset, valid bits live with the tags
  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem_reg[wr_idx] <= wr_data;
    end
  end

  assign rd_data = rd_reg;

endmodule : fpc_line_mem

/* File: verilog/fpc_array_arb.sv */
`timescale 1ns/1ns
// ==========================================================
// shares the wide array read path
module fpc_array_arb (
  input  wire logic                                  sys_clk,
  input  wire logic                                  nrst,
  input  wire logic [1:0]                            req,
  input  wire logic [1:0][fpc_pkg::LINE_A_W-1:0]     line_addr,
  input  wire logic                                  rr_mode,
  input  wire logic [fpc_pkg::WS_W-1:0]              wait_states,
  output logic                                       arr_rd_en,
  output logic      [fpc_pkg::LINE_A_W-1:0]          arr_line_addr,
  input  wire logic [fpc_pkg::LINE_W-1:0]            arr_rdata,
  output logic      [1:0]                            done,
  output logic      [fpc_pkg::LINE_W-1:0]            line_data
);

  fpc_pkg::fpc_arb_state_t         st_reg, st_next;
  logic                            own_reg, own_next;
  logic                            last_reg, last_next;
  logic [fpc_pkg::WS_W-1:0]        cnt_reg, cnt_next;
  logic                            rd_reg, rd_next;
  logic [fpc_pkg::LINE_A_W-1:0]    addr_reg, addr_next;
  logic [1:0]                      done_reg, done_next;
  logic [fpc_pkg::LINE_W-1:0]      data_reg, data_next;
  logic                            pick;

  // grant, wait-state count and capture of the line
  always_comb begin
    st_next   = st_reg;
    own_next  = own_reg;
    last_next = last_reg;
    cnt_next  = cnt_reg;
    rd_next   = 1'b0;
    addr_next = addr_reg;
    done_next = 2'h0;
    data_next = data_reg;
    pick      = 1'b0;
    unique case (st_reg)
      fpc_pkg::AS_IDLE: begin
        if (rr_mode) begin
          pick = req[~last_reg] ? ~last_reg : last_reg;
        end else begin
          pick = req[0] ? 1'b0 : 1'b1;
        end
        if (|req) begin
          own_next  = pick;
          last_next = pick;
          addr_next = line_addr[pick];
          rd_next   = 1'b1;
          cnt_next  = '0;
          st_next   = fpc_pkg::AS_BUSY;
        end
      end
      fpc_pkg::AS_BUSY: begin
        if (cnt_reg == wait_states) begin
          data_next       = arr_rdata;
          done_next[own_reg] = 1'b1;
          st_next         = fpc_pkg::AS_DONE;
        end else begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
      // one idle cycle lets the owner drop its request
      fpc_pkg::AS_DONE: begin
        st_next = fpc_pkg::AS_IDLE;
      end
      default: begin
        st_next = fpc_pkg::AS_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_reg   <= fpc_pkg::AS_IDLE;
      own_reg  <= 1'b0;
      last_reg <= 1'b1;
      cnt_reg  <= '0;
      rd_reg   <= 1'b0;
      addr_reg <= '0;
      done_reg <= 2'h0;
      data_reg <= '0;
    end else begin
      st_reg   <= st_next;
      own_reg  <= own_next;
      last_reg <= last_next;
      cnt_reg  <= cnt_next;
      rd_reg   <= rd_next;
      addr_reg <= addr_next;
      done_reg <= done_next;
      data_reg <= data_next;
    end
  end

  assign arr_rd_en     = rd_reg;
  assign arr_line_addr = addr_reg;
  assign done          = done_reg;
  assign line_data     = data_reg;

endmodule : fpc_array_arb

/* File: verilog/fpc_top.sv */
`timescale 1ns/1ns
// Behaviour
// - two independent 32-bit ahb read ports share one 128-bit array path.
// - each port owns a four-entry two-way two-set line cache.
// - each cache entry holds one 128-bit array page.
// - each port prefetches the next sequential line ahead of demand.
// - prefetch triggering is enabled per bus master by configuration.
// - triggering is limited to instruction, data or both reads.
// - a prefetched line goes into the least recently used way of its set when ways are pooled.
// - a per-port algorithm selects off, on miss, on hit or on both.
// - concurrent array requests are arbitrated as configured.
// - ways are pooled or split, way 0 instruction and way 1 data.
// - instruction fetches to the boot region end in an error when barred.
// - array wait states are configurable and reset to a safe maximum.
module fpc_top #(
  parameter logic [31:0] BOOT_BASE = 32'h0000_0000,
  parameter logic [31:0] BOOT_MASK = 32'hffff_c000
) (
  input  wire logic                         sys_clk,
  input  wire logic                         nrst,
  input  wire logic                         ahb_a_hsel,
  input  wire logic [31:0]                  ahb_a_haddr,
  input  wire logic [1:0]                   ahb_a_htrans,
  input  wire logic                         ahb_a_hwrite,
  input  wire logic [3:0]                   ahb_a_hprot,
  input  wire logic [fpc_pkg::MST_W-1:0]    ahb_a_hmaster,
  input  wire logic                         ahb_a_hready,
  output logic      [31:0]                  ahb_a_hrdata,
  output logic                              ahb_a_hreadyout,
  output logic                              ahb_a_hresp,
  input  wire logic                         ahb_b_hsel,
  input  wire logic [31:0]                  ahb_b_haddr,
  input  wire logic [1:0]                   ahb_b_htrans,
  input  wire logic                         ahb_b_hwrite,
  input  wire logic [3:0]                   ahb_b_hprot,
  input  wire logic [fpc_pkg::MST_W-1:0]    ahb_b_hmaster,
  input  wire logic                         ahb_b_hready,
  output logic      [31:0]                  ahb_b_hrdata,
  output logic                              ahb_b_hreadyout,
  output logic                              ahb_b_hresp,
  input  wire logic                         cfg_load,
  input  wire logic [fpc_pkg::CFG_W-1:0]    prefetch_config_port_a,
  input  wire logic [fpc_pkg::CFG_W-1:0]    prefetch_config_port_b,
  input  wire logic [fpc_pkg::CFG_W-1:0]    port_arbitration_config,
  output logic                              arr_rd_en,
  output logic      [fpc_pkg::LINE_A_W-1:0] arr_line_addr,
  input  wire logic [fpc_pkg::LINE_W-1:0]   arr_rdata
);

  // ==========================================================
  // configuration capture
  logic [1:0][fpc_pkg::CFG_W-1:0] pf_cfg_reg, pf_cfg_next;
  logic [fpc_pkg::CFG_W-1:0]      arb_cfg_reg, arb_cfg_next;

  // settings only move on cfg_load, so no access sees half a change
  always_comb begin
    pf_cfg_next  = pf_cfg_reg;
    arb_cfg_next = arb_cfg_reg;
    if (cfg_load) begin
      pf_cfg_next  = {prefetch_config_port_b, prefetch_config_port_a};
      arb_cfg_next = port_arbitration_config;
    end
  end

  // reset leaves the slowest array timing in place
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pf_cfg_reg  <= {fpc_pkg::PF_CFG_RST, fpc_pkg::PF_CFG_RST};
      arb_cfg_reg <= fpc_pkg::ARB_CFG_RST;
    end else begin
      pf_cfg_reg  <= pf_cfg_next;
      arb_cfg_reg <= arb_cfg_next;
    end
  end

  logic                      split_mode;
  logic                      boot_assist_exec_disable;
  logic [fpc_pkg::WS_W-1:0]  wait_states;
  assign split_mode  = arb_cfg_reg[fpc_pkg::ARB_SPLIT_BIT];
  assign boot_assist_exec_disable = arb_cfg_reg[fpc_pkg::ARB_BOOT_BIT];
  assign wait_states = arb_cfg_reg[fpc_pkg::ARB_WS_LSB +: fpc_pkg::WS_W];

  // ==========================================================
  // port bundles, index 0 is port a
  logic [1:0]                          hsel_w, hwrite_w, hready_w, hdata_w;
  logic [1:0][31:0]                    haddr_w;
  logic [1:0]                          hact_w;
  logic [1:0][fpc_pkg::MST_W-1:0]      hmst_w;
  logic [1:0][31:0]                    hrdata_w;
  logic [1:0]                          hreadyout_w, hresp_w;
  logic [1:0]                          req_w, done_w;
  logic [1:0][fpc_pkg::LINE_A_W-1:0]   req_line_w;
  logic [fpc_pkg::LINE_W-1:0]          line_data;

  assign hsel_w   = {ahb_b_hsel, ahb_a_hsel};
  assign hwrite_w = {ahb_b_hwrite, ahb_a_hwrite};
  assign hready_w = {ahb_b_hready, ahb_a_hready};
  assign haddr_w  = {ahb_b_haddr, ahb_a_haddr};
  assign hmst_w   = {ahb_b_hmaster, ahb_a_hmaster};
  assign hact_w   = {ahb_b_htrans[fpc_pkg::HTRANS_ACT_BIT],
                     ahb_a_htrans[fpc_pkg::HTRANS_ACT_BIT]};
  assign hdata_w  = {ahb_b_hprot[fpc_pkg::HPROT_DATA_BIT],
                     ahb_a_hprot[fpc_pkg::HPROT_DATA_BIT]};

  // ==========================================================
  // per-port cache controller
  for (genvar p = 0; p < fpc_pkg::N_PORTS; p++) begin : g_port
    fpc_pkg::fpc_port_state_t       st_reg, st_next;
    logic [31:0]                    addr_reg, addr_next;
    logic                           instr_reg, instr_next;
    logic [fpc_pkg::MST_W-1:0]      mst_reg, mst_next;
    logic [3:0][fpc_pkg::TAG_W-1:0] tag_reg, tag_next;
    logic [3:0]                     vld_reg, vld_next;
    logic [1:0]                     lru_reg, lru_next;
    logic                           pf_reg, pf_next;
    logic [fpc_pkg::LINE_A_W-1:0]   pf_line_reg, pf_line_next;
    logic                           pf_ins_reg, pf_ins_next;
    logic [31:0]                    hrdata_reg, hrdata_next;
    logic                           hrdy_reg, hrdy_next;
    logic                           hresp_reg, hresp_next;
    logic                           mem_wr, mem_rd;
    logic [fpc_pkg::IDX_W-1:0]      wr_idx, rd_idx;
    logic [fpc_pkg::LINE_W-1:0]     mem_rdata;
    logic                           set_b, hit, hit_way;
    logic                           nxt_hit, nxt_way;
    logic [fpc_pkg::LINE_A_W-1:0]   nxt_line;
    logic                           trig_ok, fill_way, pf_way;
    logic [1:0]                     algo;
    logic                           boot_hit, accept;

    // is a line in either way of its set
    function automatic logic [1:0] lookup(
      input logic [fpc_pkg::LINE_A_W-1:0]   line,
      input logic [3:0][fpc_pkg::TAG_W-1:0] tags,
      input logic [3:0]                     vld
    );
      logic [1:0] r;
      r = 2'h0;
      for (int w = 1; w >= 0; w--) begin
        if (vld[{line[0], w[0]}] &&
            tags[{line[0], w[0]}] == line[fpc_pkg::LINE_A_W-1:1]) begin
          r = {1'b1, w[0]};
        end
      end
      return r;
    endfunction : lookup

    assign set_b    = addr_reg[fpc_pkg::SET_BIT];
    assign {hit, hit_way} = lookup(addr_reg[31:fpc_pkg::LINE_LSB],
                                   tag_reg, vld_reg);
    assign nxt_line = addr_reg[31:fpc_pkg::LINE_LSB] + 1'b1;
    assign {nxt_hit, nxt_way} = lookup(nxt_line, tag_reg, vld_reg);
    assign algo     = pf_cfg_reg[p][fpc_pkg::PF_ALGO_LSB +: 2];
    // master and type gate on triggering
    assign trig_ok  = pf_cfg_reg[p][fpc_pkg::PF_MST_EN_LSB + mst_reg] &&
                      (instr_reg ? pf_cfg_reg[p][fpc_pkg::PF_INSTR_BIT]
                                 : pf_cfg_reg[p][fpc_pkg::PF_DATA_BIT]);
    // split: way by type; pooled: lru way
    assign fill_way = split_mode ? ~instr_reg : lru_reg[set_b];
    assign pf_way   = split_mode ? ~pf_ins_reg
                                 : lru_reg[pf_line_reg[0]];
    assign boot_hit = (haddr_w[p] & BOOT_MASK) == BOOT_BASE;
    assign accept   = hsel_w[p] && hact_w[p] && hready_w[p];
    // one request: demand miss or pending prefetch
    assign req_w[p]      = (st_reg == fpc_pkg::PS_MISS) || pf_reg;
    assign req_line_w[p] = (st_reg == fpc_pkg::PS_MISS)
                           ? addr_reg[31:fpc_pkg::LINE_LSB] : pf_line_reg;

    always_comb begin
      st_next      = st_reg;
      addr_next    = addr_reg;
      instr_next   = instr_reg;
      mst_next     = mst_reg;
      tag_next     = tag_reg;
      vld_next     = vld_reg;
      lru_next     = lru_reg;
      pf_next      = pf_reg;
      pf_line_next = pf_line_reg;
      pf_ins_next  = pf_ins_reg;
      hrdata_next  = hrdata_reg;
      hrdy_next    = hrdy_reg;
      hresp_next   = hresp_reg;
      mem_wr       = 1'b0;
      mem_rd       = 1'b0;
      wr_idx       = {set_b, fill_way};
      rd_idx       = {set_b, hit_way};
      // prefetch line landing outside a demand miss
      if (done_w[p] && st_reg != fpc_pkg::PS_MISS) begin
        mem_wr       = 1'b1;
        wr_idx       = {pf_line_reg[0], pf_way};
        tag_next[wr_idx] = pf_line_reg[fpc_pkg::LINE_A_W-1:1];
        vld_next[wr_idx] = 1'b1;
        lru_next[pf_line_reg[0]] = ~pf_way;
        pf_next      = 1'b0;
      end
      unique case (st_reg)
        fpc_pkg::PS_IDLE: begin
          hresp_next = 1'b0;
          if (accept) begin
            addr_next  = haddr_w[p];
            instr_next = ~hdata_w[p];
            mst_next   = hmst_w[p];
            hrdy_next  = 1'b0;
            // read-only flash: writes get an error too
            if (hwrite_w[p] || (~hdata_w[p] && boot_hit &&
                                boot_assist_exec_disable)) begin
              hresp_next = 1'b1;
              st_next    = fpc_pkg::PS_ERR;
            end else begin
              st_next = fpc_pkg::PS_LOOK;
            end
          end
        end
        // second error cycle
        fpc_pkg::PS_ERR: begin
          hrdy_next = 1'b1;
          st_next   = fpc_pkg::PS_IDLE;
        end
        // an in-flight prefetch is let finish first; it may be the hit
        fpc_pkg::PS_LOOK: begin
          if (!pf_reg) begin
            if (hit) begin
              mem_rd          = 1'b1;
              lru_next[set_b] = ~hit_way;
              st_next         = fpc_pkg::PS_HIT;
              if (trig_ok && algo[1] && !nxt_hit) begin
                pf_next      = 1'b1;
                pf_line_next = nxt_line;
                pf_ins_next  = instr_reg;
              end
            end else begin
              st_next = fpc_pkg::PS_MISS;
            end
          end
        end
        fpc_pkg::PS_HIT: begin
          hrdata_next = mem_rdata[{addr_reg[3:fpc_pkg::WSEL_LSB], 5'h00}
                                  +: fpc_pkg::WORD_W];
          hrdy_next   = 1'b1;
          st_next     = fpc_pkg::PS_IDLE;
        end
        // line fills the cache, wanted word goes out
        fpc_pkg::PS_MISS: begin
          if (done_w[p]) begin
            mem_wr           = 1'b1;
            wr_idx           = {set_b, fill_way};
            tag_next[wr_idx] = addr_reg[31:fpc_pkg::TAG_LSB];
            vld_next[wr_idx] = 1'b1;
            lru_next[set_b]  = ~fill_way;
            hrdata_next = line_data[{addr_reg[3:fpc_pkg::WSEL_LSB], 5'h00}
                                    +: fpc_pkg::WORD_W];
            hrdy_next   = 1'b1;
            st_next     = fpc_pkg::PS_IDLE;
            if (trig_ok && algo[0] && !nxt_hit) begin
              pf_next      = 1'b1;
              pf_line_next = nxt_line;
              pf_ins_next  = instr_reg;
            end
          end
        end
        default: begin
          st_next   = fpc_pkg::PS_IDLE;
          hrdy_next = 1'b1;
        end
      endcase
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
        st_reg      <= fpc_pkg::PS_IDLE;
        addr_reg    <= '0;
        instr_reg   <= 1'b0;
        mst_reg     <= '0;
        tag_reg     <= '0;
        vld_reg     <= 4'h0;
        lru_reg     <= 2'h0;
        pf_reg      <= 1'b0;
        pf_line_reg <= '0;
        pf_ins_reg  <= 1'b0;
        hrdata_reg  <= '0;
        hrdy_reg    <= 1'b1;
        hresp_reg   <= 1'b0;
      end else begin
        st_reg      <= st_next;
        addr_reg    <= addr_next;
        instr_reg   <= instr_next;
        mst_reg     <= mst_next;
        tag_reg     <= tag_next;
        vld_reg     <= vld_next;
        lru_reg     <= lru_next;
        pf_reg      <= pf_next;
        pf_line_reg <= pf_line_next;
        pf_ins_reg  <= pf_ins_next;
        hrdata_reg  <= hrdata_next;
        hrdy_reg    <= hrdy_next;
        hresp_reg   <= hresp_next;
      end
    end

    // four 128-bit entries, index {set, way}
    fpc_line_mem #(
      .DEPTH (fpc_pkg::N_ENTRY),
      .WIDTH (fpc_pkg::LINE_W),
      .IW    (fpc_pkg::IDX_W)
    ) u_mem (
      .sys_clk (sys_clk),
      .nrst    (nrst),
      .wr_en   (mem_wr),
      .wr_idx  (wr_idx),
      .wr_data (line_data),
      .rd_en   (mem_rd),
      .rd_idx  (rd_idx),
      .rd_data (mem_rdata)
    );

    assign hrdata_w[p]    = hrdata_reg;
    assign hreadyout_w[p] = hrdy_reg;
    assign hresp_w[p]     = hresp_reg;
  end

  // ==========================================================
  // shared array path
  fpc_array_arb u_arb (
    .sys_clk       (sys_clk),
    .nrst          (nrst),
    .req           (req_w),
    .line_addr     (req_line_w),
    .rr_mode       (arb_cfg_reg[fpc_pkg::ARB_RR_BIT]),
    .wait_states   (wait_states),
    .arr_rd_en     (arr_rd_en),
    .arr_line_addr (arr_line_addr),
    .arr_rdata     (arr_rdata),
    .done          (done_w),
    .line_data     (line_data)
  );

  assign ahb_a_hrdata    = hrdata_w[0];
  assign ahb_a_hreadyout = hreadyout_w[0];
  assign ahb_a_hresp     = hresp_w[0];
  assign ahb_b_hrdata    = hrdata_w[1];
  assign ahb_b_hreadyout = hreadyout_w[1];
  assign ahb_b_hresp     = hresp_w[1];

endmodule : fpc_top

/* File: dv/fpc_top_properties.sv */
`timescale 1ns/1ns
// ==========================================================
// port checks on ahb port a and the array path
module fpc_top_properties #(
  parameter logic [31:0] BOOT_BASE = 32'h0000_0000,
  parameter logic [31:0] BOOT_MASK = 32'hffff_c000
) (
  input wire logic        sys_clk,
  input wire logic        nrst,
  input wire logic        ahb_a_hsel,
  input wire logic [31:0] ahb_a_haddr,
  input wire logic [1:0]  ahb_a_htrans,
  input wire logic        ahb_a_hwrite,
  input wire logic [3:0]  ahb_a_hprot,
  input wire logic        ahb_a_hready,
  input wire logic        ahb_a_hreadyout,
  input wire logic        ahb_a_hresp,
  input wire logic        cfg_load,
  input wire logic [7:0]  port_arbitration_config,
  input wire logic        arr_rd_en,
  input wire logic [27:0] arr_line_addr
);
  logic bar_reg, bar_next, tk_a, bad_a;
  // boot bar mirror, live after the load
  assign bar_next = cfg_load ? port_arbitration_config[2] : bar_reg;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) bar_reg <= 1'h0;
    else bar_reg <= bar_next;
  end
  // refused: writes and barred boot fetches
  assign tk_a  = ahb_a_hsel && ahb_a_htrans[1] && ahb_a_hready;
  assign bad_a = tk_a && (ahb_a_hwrite || (bar_reg && !ahb_a_hprot[0]
                 && (ahb_a_haddr & BOOT_MASK) == BOOT_BASE));
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  property p_a_start; tk_a |=> !ahb_a_hreadyout; endproperty
  a_a_start: assert property (p_a_start) else $error("no wait");
  property p_a_done; tk_a |=> ##[1:60] ahb_a_hreadyout; endproperty
  a_a_done: assert property (p_a_done) else $error("no answer");
  property p_a_err;
    bad_a |=> (ahb_a_hresp && !ahb_a_hreadyout) ##1
      (ahb_a_hresp && ahb_a_hreadyout);
  endproperty
  a_a_err: assert property (p_a_err) else $error("no error");
  property p_a_ok;
    tk_a && !bad_a |=> (!ahb_a_hreadyout && !ahb_a_hresp) [*2];
  endproperty
  a_a_ok: assert property (p_a_ok) else $error("early answer");
  property p_pulse; arr_rd_en |=> !arr_rd_en [*2]; endproperty
  a_pulse: assert property (p_pulse) else $error("array spacing");
  property p_addr_held; $changed(arr_line_addr) |-> arr_rd_en; endproperty
  a_addr_held: assert property (p_addr_held) else $error("addr moved");
  property p_resp_drop;
    ahb_a_hresp && ahb_a_hreadyout && !tk_a |=> !ahb_a_hresp;
  endproperty
  a_resp_drop: assert property (p_resp_drop) else $error("resp stuck");
  property p_resp_cause; $rose(ahb_a_hresp) |-> $past(bad_a); endproperty
  a_resp_cause: assert property (p_resp_cause) else $error("bad resp");
  c_bad: cover property (bad_a);
  c_arr: cover property (arr_rd_en);
  c_hit: cover property (tk_a ##3 ahb_a_hreadyout);
endmodule : fpc_top_properties
bind fpc_top fpc_top_properties #(.BOOT_BASE(BOOT_BASE),
  .BOOT_MASK(BOOT_MASK)) fpc_top_properties_inst (.*);

/* File: dv/fpc_array_model.sv */
`timescale 1ns/1ns
// ==========================================================
// array stand-in: a line is valid only in its sample cycle
module fpc_array_model (
  input  wire logic         sys_clk,
  input  wire logic         nrst,
  input  wire logic         rd_en,
  input  wire logic [27:0]  line_addr,
  input  wire logic [3:0]   wait_states,
  output logic      [127:0] rdata
);
  logic [3:0]   cnt_reg, cnt_next;
  logic         act_reg, act_next;
  logic [127:0] pat;
  // wait-state countdown; inverse shown otherwise, so stale data fails
  always_comb begin
    cnt_next = act_reg ? cnt_reg - 4'h1 : cnt_reg;
    act_next = act_reg && cnt_reg != 4'h1;
    if (rd_en) begin
      cnt_next = wait_states;
      act_next = wait_states != 4'h0;
    end
    for (int k = 0; k < 4; k++) pat[32*k +: 32] = {line_addr, k[1:0], 2'h0};
    rdata = ((rd_en && wait_states == 4'h0) || (act_reg && cnt_reg == 4'h1))
            ? pat : ~pat;
  end
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= 4'h0;
      act_reg <= 1'h0;
    end else begin
      cnt_reg <= cnt_next;
      act_reg <= act_next;
    end
  end
endmodule : fpc_array_model

/* File: dv/flash_read_prefetch_controller_test.sv */
`timescale 1ns/1ns
module flash_read_prefetch_controller_test;
  logic         sys_clk = 1'h0, nrst = 1'h0, ld = 1'h0, ya, yb, ea, eb, en;
  logic [1:0]   sel = 2'h0, wr = 2'h0, dt = 2'h0, mst = 2'h0;
  logic [31:0]  aa = 32'h0, ab = 32'h0, ra, rb;
  logic [7:0]   pa = 8'h0, pb = 8'h0, ar = 8'h0;
  logic [3:0]   ws = 4'hf;
  logic [27:0]  la, la1;
  logic [127:0] ad;
  int           num_errors = 0, n_checks = 0, cyc = 0, n_arr = 0;
  fpc_top fpc_top_inst (.sys_clk(sys_clk), .nrst(nrst), .ahb_a_hsel(sel[0]),
    .ahb_a_haddr(aa), .ahb_a_htrans({sel[0], 1'h0}), .ahb_a_hwrite(wr[0]),
    .ahb_a_hprot({3'h0, dt[0]}), .ahb_a_hmaster(mst), .ahb_a_hready(ya),
    .ahb_a_hrdata(ra), .ahb_a_hreadyout(ya), .ahb_a_hresp(ea),
    .ahb_b_hsel(sel[1]), .ahb_b_haddr(ab), .ahb_b_htrans({sel[1], 1'h0}),
    .ahb_b_hwrite(wr[1]), .ahb_b_hprot({3'h0, dt[1]}), .ahb_b_hmaster(mst),
    .ahb_b_hready(yb), .ahb_b_hrdata(rb), .ahb_b_hreadyout(yb),
    .ahb_b_hresp(eb), .cfg_load(ld), .prefetch_config_port_a(pa),
    .prefetch_config_port_b(pb), .port_arbitration_config(ar),
    .arr_rd_en(en), .arr_line_addr(la), .arr_rdata(ad));
  fpc_array_model fpc_array_model_inst (.sys_clk(sys_clk), .nrst(nrst),
    .rd_en(en), .line_addr(la), .wait_states(ws), .rdata(ad));
  always #5 sys_clk = ~sys_clk;
  // array read count, first line, hang limit
  always @(posedge sys_clk) begin
    cyc++;
    if (en && n_arr == 0) la1 = la;
    if (en) n_arr++;
    if (cyc == 6000) begin
      num_errors++;
      report_and_stop();
    end
  end
  task automatic chk(input string nm, input logic [31:0] s, e);
    n_checks++;
    if (s !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic cfg(input logic [7:0] a, b, c);
    @(negedge sys_clk);
    {pa, pb, ar, ld, ws} = {a, b, c, 1'h1, c[7:4]};
    @(negedge sys_clk);
    ld = 1'h0;
  endtask : cfg
  // k = {data, write, error}; port b reads the next line; n < 0 skips
  task automatic xfer(input logic [1:0] pm, input logic [31:0] a,
    input logic [2:0] k, input int n);
    repeat (20) @(negedge sys_clk);
    n_arr = 0;
    {aa, ab, dt, wr, sel} = {a, a + 32'h10, {2{k[2]}}, {2{k[1]}}, pm};
    @(negedge sys_clk);
    sel = 2'h0;
    for (int i = 0; i < 60 && !(ya && yb); i++) @(negedge sys_clk);
    chk("resp", {30'h0, {eb, ea} & pm}, {30'h0, pm & {2{k[0]}}});
    if (!k[0] && pm[0]) chk("data_a", ra, {a[31:2], 2'h0});
    if (!k[0] && pm[1]) chk("data_b", rb, {ab[31:2], 2'h0});
    if (n >= 0) chk("arr_reads", n_arr, n);
  endtask : xfer
  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : report_and_stop
  // scenarios: prefetch, master, type, algorithm, boot, arbitration, lru, split, round robin
  initial begin
    repeat (20) @(negedge sys_clk);
    chk("idle_rdy", {30'h0, yb, ya}, 32'h3);
    nrst = 1'h1;
    xfer(2'h1, 32'h8100, 3'h4, 1);
    cfg(8'h00, 8'h00, 8'h20);
    xfer(2'h1, 32'h810c, 3'h4, 0);
    xfer(2'h1, 32'h8110, 3'h4, 1);
    cfg(8'h71, 8'h00, 8'h20);
    xfer(2'h1, 32'h8300, 3'h0, -1);
    xfer(2'h1, 32'h8314, 3'h0, 0);
    mst = 2'h1;
    xfer(2'h1, 32'h8400, 3'h4, -1);
    xfer(2'h1, 32'h8410, 3'h4, 1);
    mst = 2'h0;
    cfg(8'h61, 8'h00, 8'h20);
    xfer(2'h1, 32'h8500, 3'h0, -1);
    xfer(2'h1, 32'h8510, 3'h0, 1);
    xfer(2'h1, 32'h8600, 3'h4, -1);
    xfer(2'h1, 32'h8618, 3'h4, 0);
    cfg(8'hb1, 8'h00, 8'h20);
    xfer(2'h1, 32'h8700, 3'h4, -1);
    xfer(2'h1, 32'h8704, 3'h4, -1);
    xfer(2'h1, 32'h8710, 3'h4, 0);
    cfg(8'h00, 8'h00, 8'h24);
    xfer(2'h1, 32'h0100, 3'h1, 0);
    xfer(2'h1, 32'h0104, 3'h4, 1);
    xfer(2'h1, 32'h8800, 3'h7, 0);
    cfg(8'h00, 8'h00, 8'h20);
    xfer(2'h3, 32'h8900, 3'h4, 2);
    chk("first_line", {4'h0, la1}, 32'h890);
    xfer(2'h1, 32'h9000, 3'h4, 1);
    xfer(2'h1, 32'h9020, 3'h4, 1);
    xfer(2'h1, 32'h9008, 3'h4, 0);
    xfer(2'h1, 32'h9040, 3'h4, 1);
    xfer(2'h1, 32'h9004, 3'h4, 0);
    cfg(8'h00, 8'h00, 8'h22);
    xfer(2'h1, 32'h9100, 3'h4, 1);
    xfer(2'h1, 32'h9120, 3'h4, 1);
    xfer(2'h1, 32'h9100, 3'h4, 1);
    cfg(8'h00, 8'h00, 8'h21);
    xfer(2'h1, 32'h8a00, 3'h4, 1);
    xfer(2'h3, 32'h8b00, 3'h4, 2);
    chk("first_line", {4'h0, la1}, 32'h8b1);
    report_and_stop();
  end
endmodule : flash_read_prefetch_controller_test
